//--- design/sttr_pkg.sv
// constants for the split timer, timer rate control and timer two block
package sttr_pkg;
  // special-function register addresses
  localparam logic [7:0] ADDR_TIMER_CLOCK_RATE_CONTROL = 8'h8e;
  localparam logic [7:0] ADDR_TIMER2_CONTROL           = 8'hc8;
  localparam logic [7:0] ADDR_TIMER2_RELOAD_LOW        = 8'hca;
  localparam logic [7:0] ADDR_TIMER2_RELOAD_HIGH       = 8'hcb;
  localparam logic [7:0] ADDR_TIMER2_COUNT_LOW         = 8'hcc;
  localparam logic [7:0] ADDR_TIMER2_COUNT_HIGH        = 8'hcd;
  // timer zero and one count bytes
  localparam logic [7:0] ADDR_TIMER_ZERO_LOW           = 8'h8a;
  localparam logic [7:0] ADDR_TIMER_ONE_LOW            = 8'h8b;
  localparam logic [7:0] ADDR_TIMER_ZERO_HIGH          = 8'h8c;
  localparam logic [7:0] ADDR_TIMER_ONE_HIGH           = 8'h8d;
  // clock-rate control fields
  localparam int         BIT_TIMER_TWO_RATE            = 5;
  localparam int         BIT_TIMER_ONE_RATE            = 4;
  localparam int         BIT_TIMER_ZERO_RATE           = 3;
  localparam logic [7:0] CLOCK_RATE_WRITE_MASK         = 8'h3f;
  localparam logic [7:0] CLOCK_RATE_RESET              = 8'h01;
  localparam logic [3:0] ACCESS_BASE_CYCLES            = 4'h2;
  // timer two control fields
  localparam int         BIT_TF2                       = 7;
  localparam int         BIT_TIMER_TWO_EXTERNAL_FLAG                      = 6;
  localparam int         BIT_RX_CLOCK_SELECT           = 5;
  localparam int         BIT_TX_CLOCK_SELECT           = 4;
  localparam int         BIT_TRIGGER_ENABLE            = 3;
  localparam int         BIT_TIMER_TWO_RUN             = 2;
  localparam int         BIT_TIMER_TWO_COUNTER         = 1;
  localparam int         BIT_CAPTURE_SELECT            = 0;
  // prescaler: one counter serves the /2, /4 and /12 time bases
  localparam logic [3:0] PRESCALE_LAST                 = 4'hb;
  // pin vector positions
  localparam int         PIN_T0                        = 0;
  localparam int         PIN_T1                        = 1;
  localparam int         PIN_T2                        = 2;
  localparam int         PIN_TIMER_TWO_TRIGGER_PIN                      = 3;
  localparam int         PIN_INT0                      = 4;
  localparam int         PIN_INT1                      = 5;
  localparam int         PIN_COUNT                     = 6;
  // timer one mode codes
  localparam logic [1:0] T1_MODE_13BIT                 = 2'h0;
  localparam logic [1:0] T1_MODE_RELOAD8               = 2'h2;
  localparam logic [1:0] T1_MODE_STOP                  = 2'h3;
  // timer two operating modes
  typedef enum logic [1:0] {SttrOff, SttrCapture, SttrReload, SttrBaud} sttr_t2mode_e;
endpackage

//--- design/sttr_timers.sv
// timer zero split mode, timer one, clock-rate control and timer two
`timescale 1ns/10ps
module sttr_timers
  import sttr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [7:0]           sfr_addr,                  // special-function address
  input  wire logic                 sfr_write,                 // write strobe, one cycle
  input  wire logic [7:0]           sfr_wdata,                 // write data
  output logic      [7:0]           sfr_rdata,                 // read data, one cycle later
  input  wire logic [PIN_COUNT-1:0] pins,                      // raw pins, see package
  input  wire logic                 timer_zero_split,          // timer zero in mode 3
  input  wire logic                 timer_zero_run_bit,
  input  wire logic                 timer_zero_gate,
  input  wire logic                 timer_zero_counter_select,
  input  wire logic [1:0]           timer_one_mode,
  input  wire logic                 timer_one_run_bit,
  input  wire logic                 timer_one_gate,
  input  wire logic                 timer_one_counter_select,
  input  wire logic                 timer2_interrupt_enable,
  output logic                      timer_zero_overflow_set,   // pulse to overflow flag zero
  output logic                      timer_one_overflow_set,    // pulse to overflow flag one
  output logic                      timer2_interrupt_request,  // level
  output logic                      serial_receive_tick,       // pulse
  output logic                      serial_transmit_tick,      // pulse
  output logic      [3:0]           external_access_cycles     // data-move length
);

  // registers
  logic [7:0]   timer_clock_rate_control;
  logic [7:0]   timer2_control;
  logic [7:0]   timer2_reload_capture_low;
  logic [7:0]   timer2_reload_capture_high;
  logic [7:0]   timer2_count_low;
  logic [7:0]   timer2_count_high;
  logic [7:0]   timer_zero_low_byte;
  logic [7:0]   timer_zero_high_byte;
  logic [7:0]   timer_one_low_byte;
  logic [7:0]   timer_one_high_byte;
  // pin synchronisers and edge detection
  logic [PIN_COUNT-1:0] pin_s1;       // first stage, read only by the second
  logic [PIN_COUNT-1:0] pin_s2;
  logic [PIN_COUNT-1:0] pin_s3;
  logic [PIN_COUNT-1:0] pin_level;    // filtered level
  logic [PIN_COUNT-1:0] pin_level_d;  // previous filtered level
  logic [PIN_COUNT-1:0] pin_fall;
  // prescaler
  logic [3:0]   prescale;
  logic         tick2;
  logic         tick4;
  logic         tick12;

  // choose /4 or /12 time base from a rate bit
  function automatic logic rate_tick(input logic fast, input logic t4, input logic t12);
    rate_tick = fast ? t4 : t12;
  endfunction

  // one-byte register write decode
  function automatic logic hit(input logic [7:0] a, input logic wr, input logic [7:0] want);
    hit = wr && (a == want);
  endfunction

  // three-stage synchronisers; a level counts once stages two and three agree
  // synchronise and detect falls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1      <= '1;
      pin_s2      <= '1;
      pin_s3      <= '1;
      pin_level   <= '1;
      pin_level_d <= '1;
    end else begin
      pin_s1      <= pins;
      pin_s2      <= pin_s1;
      pin_s3      <= pin_s2;
      pin_level_d <= pin_level;
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_level[i] <= pin_s3[i];
        end
      end
    end
  end
  assign pin_fall = pin_level_d & ~pin_level;

  // free-running prescaler 0..11
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prescale <= '0;
    end else begin
      prescale <= (prescale == PRESCALE_LAST) ? 4'h0 : prescale + 4'h1;
    end
  end
  assign tick2  = prescale[0];
  assign tick4  = (prescale[1:0] == 2'h3);
  assign tick12 = (prescale == PRESCALE_LAST);

  // clock-rate control register
  // rate bits reset to zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_clock_rate_control <= CLOCK_RATE_RESET;
    end else if (hit(sfr_addr, sfr_write, ADDR_TIMER_CLOCK_RATE_CONTROL)) begin
      timer_clock_rate_control <= sfr_wdata & CLOCK_RATE_WRITE_MASK;  // bits 7,6 reserved
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      external_access_cycles <= ACCESS_BASE_CYCLES + 4'h1;
    end else begin
      external_access_cycles <= ACCESS_BASE_CYCLES + {1'b0, timer_clock_rate_control[2:0]};
    end
  end

  // ---------------- timer zero ----------------
  logic t0_enable;   // low byte enable, gate hands control to int0
  logic t0_inc;
  logic t0h_inc;
  logic t0_ovf;
  logic t0h_ovf;
  assign t0_enable = timer_zero_run_bit && (!timer_zero_gate || pin_level[PIN_INT0]);
  assign t0_inc    = t0_enable && (timer_zero_counter_select ? pin_fall[PIN_T0] :
                     rate_tick(timer_clock_rate_control[BIT_TIMER_ZERO_RATE], tick4, tick12));
  // high byte: divided clocks, run-one enable
  assign t0h_inc   = timer_zero_split && timer_one_run_bit &&
                     rate_tick(timer_clock_rate_control[BIT_TIMER_ZERO_RATE], tick4, tick12);
  assign t0_ovf    = t0_inc && (timer_zero_low_byte == 8'hff) &&
                     (timer_zero_split || (timer_zero_high_byte == 8'hff));
  assign t0h_ovf   = t0h_inc && (timer_zero_high_byte == 8'hff);

  // timer zero counts; outside split it runs as one sixteen-bit count
  // two separate byte counters when split
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_zero_low_byte  <= '0;
      timer_zero_high_byte <= '0;
    end else begin
      if (hit(sfr_addr, sfr_write, ADDR_TIMER_ZERO_LOW)) begin
        timer_zero_low_byte <= sfr_wdata;
      end else if (t0_inc) begin
        timer_zero_low_byte <= timer_zero_low_byte + 8'h01;
      end
      if (hit(sfr_addr, sfr_write, ADDR_TIMER_ZERO_HIGH)) begin
        timer_zero_high_byte <= sfr_wdata;
      end else if (timer_zero_split ? t0h_inc : (t0_inc && timer_zero_low_byte == 8'hff)) begin
        timer_zero_high_byte <= timer_zero_high_byte + 8'h01;
      end
    end
  end

  // ---------------- timer one ----------------
  logic t1_enable;
  logic t1_inc;
  logic t1_low_full;  // low part at its top count for the current mode
  logic t1_ovf;
  // mode field runs or halts timer one when split
  // own select, rate and gate kept
  assign t1_enable   = (timer_zero_split ? (timer_one_mode != T1_MODE_STOP) : timer_one_run_bit)
                       && (!timer_one_gate || pin_level[PIN_INT1]);
  assign t1_inc      = t1_enable && (timer_one_counter_select ? pin_fall[PIN_T1] :
                       rate_tick(timer_clock_rate_control[BIT_TIMER_ONE_RATE], tick4, tick12));
  assign t1_low_full = (timer_one_mode == T1_MODE_13BIT) ? (timer_one_low_byte[4:0] == 5'h1f) :
                       (timer_one_low_byte == 8'hff);
  assign t1_ovf      = t1_inc && t1_low_full &&
                       ((timer_one_mode == T1_MODE_RELOAD8) || (timer_one_high_byte == 8'hff));

  // timer one counts; when split, mode 3 never reaches here since the enable drops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_one_low_byte  <= '0;
      timer_one_high_byte <= '0;
    end else begin
      if (hit(sfr_addr, sfr_write, ADDR_TIMER_ONE_LOW)) begin
        timer_one_low_byte <= sfr_wdata;
      end else if (t1_inc) begin
        if (!t1_low_full) begin
          timer_one_low_byte <= timer_one_low_byte + 8'h01;
        end else if (timer_one_mode == T1_MODE_RELOAD8) begin
          timer_one_low_byte <= timer_one_high_byte;
        end else begin
          timer_one_low_byte <= '0;
        end
      end
      if (hit(sfr_addr, sfr_write, ADDR_TIMER_ONE_HIGH)) begin
        timer_one_high_byte <= sfr_wdata;
      end else if (t1_inc && t1_low_full && timer_one_mode != T1_MODE_RELOAD8) begin
        timer_one_high_byte <= timer_one_high_byte + 8'h01;
      end
    end
  end

  // ---------------- timer two ----------------
  sttr_t2mode_e t2_mode;
  logic         t2_serial;   // either serial clock select set
  logic         t2_inc;
  logic         t2_ovf;
  logic         t2_trigger;  // enabled falling edge on the trigger pin
  logic         t2_capture;
  logic         t2_reload;
  logic         wr_timer2_control;
  logic [15:0]  t2_count;

  assign t2_count  = {timer2_count_high, timer2_count_low};
  assign t2_serial = timer2_control[BIT_RX_CLOCK_SELECT] || timer2_control[BIT_TX_CLOCK_SELECT];
  assign wr_timer2_control  = hit(sfr_addr, sfr_write, ADDR_TIMER2_CONTROL);

  always_comb begin
    if (!timer2_control[BIT_TIMER_TWO_RUN]) begin
      t2_mode = SttrOff;
    end else if (t2_serial) begin
      t2_mode = SttrBaud;
    end else if (timer2_control[BIT_CAPTURE_SELECT]) begin
      t2_mode = SttrCapture;
    end else begin
      t2_mode = SttrReload;
    end
  end

  // baud mode uses the two-clock base unless the counter select picks the T2 pin
  assign t2_inc = (t2_mode != SttrOff) &&
                  (timer2_control[BIT_TIMER_TWO_COUNTER] ? pin_fall[PIN_T2] :
                   (t2_mode == SttrBaud) ? tick2 :
                   rate_tick(timer2_control[BIT_TIMER_TWO_RUN] &&
                             timer_clock_rate_control[BIT_TIMER_TWO_RATE], tick4, tick12));
  assign t2_ovf = t2_inc && (t2_count == 16'hffff);

  // trigger edges only with enable; in baud mode they only set the external flag
  // capture bit, serial selects force reload
  assign t2_trigger = pin_fall[PIN_TIMER_TWO_TRIGGER_PIN] && timer2_control[BIT_TRIGGER_ENABLE];
  assign t2_capture = t2_trigger && !t2_serial && timer2_control[BIT_CAPTURE_SELECT];
  assign t2_reload  = (t2_trigger && !t2_serial && !timer2_control[BIT_CAPTURE_SELECT]) ||
                      (t2_ovf && t2_mode != SttrCapture);

  // timer two count; a software write beats a count or reload in the same cycle
  // overflow loads reload bytes except in capture mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer2_count_low  <= '0;
      timer2_count_high <= '0;
    end else begin
      if (hit(sfr_addr, sfr_write, ADDR_TIMER2_COUNT_LOW)) begin
        timer2_count_low <= sfr_wdata;
      end else if (t2_reload) begin
        timer2_count_low <= timer2_reload_capture_low;
      end else if (t2_inc) begin
        timer2_count_low <= timer2_count_low + 8'h01;
      end
      if (hit(sfr_addr, sfr_write, ADDR_TIMER2_COUNT_HIGH)) begin
        timer2_count_high <= sfr_wdata;
      end else if (t2_reload) begin
        timer2_count_high <= timer2_reload_capture_high;
      end else if (t2_inc && timer2_count_low == 8'hff) begin
        timer2_count_high <= timer2_count_high + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer2_reload_capture_low  <= '0;
      timer2_reload_capture_high <= '0;
    end else begin
      if (t2_capture) begin
        timer2_reload_capture_low <= timer2_count_low;
      end else if (hit(sfr_addr, sfr_write, ADDR_TIMER2_RELOAD_LOW)) begin
        timer2_reload_capture_low <= sfr_wdata;
      end
      if (t2_capture) begin
        timer2_reload_capture_high <= timer2_count_high;
      end else if (hit(sfr_addr, sfr_write, ADDR_TIMER2_RELOAD_HIGH)) begin
        timer2_reload_capture_high <= sfr_wdata;
      end
    end
  end

  // timer two control; hardware sets beat a software clear in the same cycle
  // overflow flag only without serial selects
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer2_control <= '0;
    end else begin
      if (wr_timer2_control) begin
        timer2_control <= sfr_wdata;
      end
      if (t2_ovf && !t2_serial) begin
        timer2_control[BIT_TF2] <= 1'b1;
      end
      if (t2_trigger) begin
        timer2_control[BIT_TIMER_TWO_EXTERNAL_FLAG] <= 1'b1;
      end
    end
  end

  // registered outputs toward the core and the serial port
  // split overflows drive flags zero and one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_zero_overflow_set  <= 1'b0;
      timer_one_overflow_set   <= 1'b0;
      timer2_interrupt_request <= 1'b0;
      serial_receive_tick      <= 1'b0;
      serial_transmit_tick     <= 1'b0;
    end else begin
      timer_zero_overflow_set  <= t0_ovf;
      timer_one_overflow_set   <= timer_zero_split ? t0h_ovf : t1_ovf;
      timer2_interrupt_request <= timer2_interrupt_enable &&
                                  (timer2_control[BIT_TF2] || timer2_control[BIT_TIMER_TWO_EXTERNAL_FLAG]);
      serial_receive_tick      <= timer2_control[BIT_RX_CLOCK_SELECT] ? t2_ovf : t1_ovf;
      serial_transmit_tick     <= timer2_control[BIT_TX_CLOCK_SELECT] ? t2_ovf : t1_ovf;
    end
  end

  // read mux, registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= '0;
    end else begin
      unique case (sfr_addr)
        ADDR_TIMER_CLOCK_RATE_CONTROL: sfr_rdata <= timer_clock_rate_control;
        ADDR_TIMER2_CONTROL:           sfr_rdata <= timer2_control;
        ADDR_TIMER2_RELOAD_LOW:        sfr_rdata <= timer2_reload_capture_low;
        ADDR_TIMER2_RELOAD_HIGH:       sfr_rdata <= timer2_reload_capture_high;
        ADDR_TIMER2_COUNT_LOW:         sfr_rdata <= timer2_count_low;
        ADDR_TIMER2_COUNT_HIGH:        sfr_rdata <= timer2_count_high;
        ADDR_TIMER_ZERO_LOW:           sfr_rdata <= timer_zero_low_byte;
        ADDR_TIMER_ZERO_HIGH:          sfr_rdata <= timer_zero_high_byte;
        ADDR_TIMER_ONE_LOW:            sfr_rdata <= timer_one_low_byte;
        ADDR_TIMER_ONE_HIGH:           sfr_rdata <= timer_one_high_byte;
        default:                       sfr_rdata <= '0;
      endcase
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic wr_t1;  // any write to timer one bytes
  logic wr_t2;  // any write to timer two count bytes
  assign wr_t1 = hit(sfr_addr, sfr_write, ADDR_TIMER_ONE_LOW) ||
                 hit(sfr_addr, sfr_write, ADDR_TIMER_ONE_HIGH);
  assign wr_t2 = hit(sfr_addr, sfr_write, ADDR_TIMER2_COUNT_LOW) ||
                 hit(sfr_addr, sfr_write, ADDR_TIMER2_COUNT_HIGH);

  chk_split_one_holds: assert property (
    timer_zero_split && timer_one_mode == T1_MODE_STOP && !wr_t1 |=>
    $stable(timer_one_low_byte) && $stable(timer_one_high_byte))
    else $error("timer one moved while stopped in split mode");
  chk_slow_tick_gap: assert property (
    tick12 |=> !tick12 [*8])
    else $error("twelve-clock base fired too soon");
  chk_overflow_flag: assert property (
    t2_ovf && !t2_serial |=> timer2_control[BIT_TF2])
    else $error("overflow flag not set on rollover");
  chk_baud_no_flag: assert property (
    t2_mode == SttrBaud && !timer2_control[BIT_TF2] && !wr_timer2_control |=> !timer2_control[BIT_TF2])
    else $error("baud mode set the overflow flag");
  chk_reload_value: assert property (
    t2_ovf && t2_mode == SttrReload && !wr_t2 |=>
    t2_count == {$past(timer2_reload_capture_high), $past(timer2_reload_capture_low)})
    else $error("auto-reload loaded wrong value");
  chk_capture_value: assert property (
    t2_capture |=> {timer2_reload_capture_high, timer2_reload_capture_low} == $past(t2_count))
    else $error("capture missed the count");
  chk_external_flag: assert property (
    t2_trigger |=> timer2_control[BIT_TIMER_TWO_EXTERNAL_FLAG])
    else $error("external flag not set by trigger");
  chk_irq_follows: assert property (
    timer2_interrupt_enable && timer2_control[BIT_TF2] |=> timer2_interrupt_request)
    else $error("interrupt request missing");
  chk_run_hold: assert property (
    !timer2_control[BIT_TIMER_TWO_RUN] && !wr_t2 && !t2_trigger |=> $stable(t2_count))
    else $error("stopped timer two changed");
  chk_serial_rx: assert property (
    t2_ovf && timer2_control[BIT_RX_CLOCK_SELECT] |=> serial_receive_tick)
    else $error("receive tick missing on timer two overflow");

endmodule

//--- tb/sttr_serial_model.sv
// serial port stand-in: counts shift ticks and times the transmit tick spacing
`timescale 1ns/10ps
module sttr_serial_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        rx_tick,
  input  wire logic        tx_tick,
  output logic      [31:0] rx_count,
  output logic      [15:0] tx_gap
);
  logic [15:0] since;  // cycles since the last transmit tick
  // the port only consumes ticks, it never pushes back on the timer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_count <= '0;
      tx_gap   <= '0;
      since    <= '0;
    end else begin
      since <= tx_tick ? 16'h1 : since + 16'h1;
      if (tx_tick) tx_gap <= since;
      if (rx_tick) rx_count <= rx_count + 32'h1;
    end
  end
endmodule

//--- tb/sttr_timers_tb.sv
// self-checking bench for the split timer, rate control and timer two block
`timescale 1ns/10ps
module sttr_timers_tb import sttr_pkg::*; ;
  logic        clk = 1'b0, nrst = 1'b0, w = 1'b0, zs = 1'b0, ors = 1'b1, ie = 1'b0;
  logic [7:0]  a = 8'h00, wd = 8'h00, rdat;
  logic [5:0]  pins = 6'h3f;  // pins idle high, interrupt pins deasserted
  logic [1:0]  om = 2'h0;
  logic        zcs = 1'b0, ocs = 1'b0;  // counter selects of timers zero and one
  logic        zo, oo, irq, rxt, txt;
  logic [3:0]  acc;
  logic [15:0] r, v, gap;
  logic [31:0] rxn;
  integer      mismatches = 0, checked = 0, seed = 32'hd69b, cyc = 0;
  always #2 clk = ~clk;
  sttr_timers uut (.clk(clk), .nrst(nrst), .sfr_addr(a), .sfr_write(w), .sfr_wdata(wd),
    .sfr_rdata(rdat), .pins(pins), .timer_zero_split(zs), .timer_zero_run_bit(1'b1),
    .timer_zero_gate(1'b0), .timer_zero_counter_select(zcs), .timer_one_mode(om),
    .timer_one_run_bit(ors), .timer_one_gate(1'b0), .timer_one_counter_select(ocs),
    .timer2_interrupt_enable(ie), .timer_zero_overflow_set(zo), .timer_one_overflow_set(oo),
    .timer2_interrupt_request(irq), .serial_receive_tick(rxt), .serial_transmit_tick(txt),
    .external_access_cycles(acc));
  sttr_serial_model port (.clk(clk), .nrst(nrst), .rx_tick(rxt), .tx_tick(txt),
    .rx_count(rxn), .tx_gap(gap));
  task automatic end_sim;
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs move on the falling edge, away from the sampling edge
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk) begin a = ad; wd = d; w = 1'b1; end
    @(negedge clk) w = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(negedge clk) a = ad;
    @(negedge clk) d = rdat;
  endtask
  function automatic logic sel(input int k);
    return (k == 0) ? irq : (k == 1) ? oo : zo;
  endfunction
  // bounded wait, sampled mid-cycle so a one-cycle pulse is seen
  task automatic waitfor(input int k, input int lim);
    for (int n = 0; n < lim && sel(k) !== 1'b1; n++) @(negedge clk);
  endtask
  task automatic pulse(input int p);
    pins[p] = 1'b0;
    repeat (6) @(negedge clk);
    pins[p] = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // run timer two from zero for a window, return the low count
  task automatic run2(input logic [7:0] ctl, input logic [7:0] rate, input int np, input int c);
    wr(ADDR_TIMER2_CONTROL, 8'h00);
    wr(ADDR_TIMER_CLOCK_RATE_CONTROL, rate);
    wr(ADDR_TIMER2_COUNT_LOW, 8'h00);
    wr(ADDR_TIMER2_COUNT_HIGH, 8'h00);
    wr(ADDR_TIMER2_CONTROL, ctl);
    repeat (np) pulse(PIN_T2);
    repeat (c) @(negedge clk);
    wr(ADDR_TIMER2_CONTROL, 8'h00);
    rd(ADDR_TIMER2_COUNT_LOW, v[7:0]);
  endtask
  function automatic logic near(input logic [7:0] got, input int e);
    return (int'(got) >= e - 1) && (int'(got) <= e + 1);
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    rd(ADDR_TIMER_CLOCK_RATE_CONTROL, v[7:0]);
    chk(v[7:0], CLOCK_RATE_RESET);
    chk(acc, 4'h3);
    wr(ADDR_TIMER_CLOCK_RATE_CONTROL, 8'hff);
    rd(ADDR_TIMER_CLOCK_RATE_CONTROL, v[7:0]);
    chk(v[7:0], 8'h3f);
    chk(acc, ACCESS_BASE_CYCLES + 4'h7);
    rd(8'h90, v[7:0]);
    chk(v[7:0], 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = 16'($random(seed));
      wr(ADDR_TIMER2_COUNT_LOW, r[7:0]);
      wr(ADDR_TIMER2_COUNT_HIGH, r[15:8]);
      rd(ADDR_TIMER2_COUNT_LOW, v[7:0]);
      rd(ADDR_TIMER2_COUNT_HIGH, v[15:8]);
      chk(v, r);
    end
    // other timers' rate bits must not speed timer two up
    for (int i = 0; i < 2; i++) begin
      run2(8'h04, i ? 8'h20 : 8'h18, 0, 48);
      chk(near(v[7:0], i ? 12 : 4), 1'b1);
    end
    run2(8'h06, 8'h20, 5, 8);
    chk(v[7:0], 8'h05);
    ie = 1'b1;
    wr(ADDR_TIMER2_RELOAD_LOW, 8'hfe);
    wr(ADDR_TIMER2_RELOAD_HIGH, 8'hff);
    wr(ADDR_TIMER2_COUNT_LOW, 8'hff);
    wr(ADDR_TIMER2_COUNT_HIGH, 8'hff);
    wr(ADDR_TIMER2_CONTROL, 8'h04);
    waitfor(0, 40);
    chk(irq, 1'b1);
    rd(ADDR_TIMER2_CONTROL, v[7:0]);
    chk(v[7], 1'b1);
    wr(ADDR_TIMER2_CONTROL, 8'h00);
    rd(ADDR_TIMER2_COUNT_HIGH, v[7:0]);
    chk(v[7:0], 8'hff);
    chk(irq, 1'b0);
    wr(ADDR_TIMER2_CONTROL, 8'h40);
    @(negedge clk);
    chk(irq, 1'b1);
    wr(ADDR_TIMER2_CONTROL, 8'h00);
    wr(ADDR_TIMER2_RELOAD_LOW, 8'hf0);
    wr(ADDR_TIMER2_CONTROL, 8'h34);
    repeat (200) @(negedge clk);
    chk(gap, 16'h0020);
    chk(rxn != 0, 1'b1);
    rd(ADDR_TIMER2_CONTROL, v[7:0]);
    chk(v[7], 1'b0);
    r = 16'($random(seed));
    wr(ADDR_TIMER2_CONTROL, 8'h09);
    wr(ADDR_TIMER2_COUNT_LOW, r[7:0]);
    wr(ADDR_TIMER2_COUNT_HIGH, r[15:8]);
    pulse(PIN_TIMER_TWO_TRIGGER_PIN);
    rd(ADDR_TIMER2_RELOAD_LOW, v[7:0]);
    rd(ADDR_TIMER2_RELOAD_HIGH, v[15:8]);
    chk(v, r);
    rd(ADDR_TIMER2_CONTROL, v[7:0]);
    chk(v[6], 1'b1);
    wr(ADDR_TIMER2_CONTROL, 8'h01);
    wr(ADDR_TIMER2_COUNT_LOW, ~r[7:0]);
    pulse(PIN_TIMER_TWO_TRIGGER_PIN);
    rd(ADDR_TIMER2_RELOAD_LOW, v[7:0]);
    chk(v[7:0], r[7:0]);
    zs = 1'b1;
    om = T1_MODE_STOP;
    wr(ADDR_TIMER_CLOCK_RATE_CONTROL, 8'h08);
    rd(ADDR_TIMER_ONE_LOW, v[7:0]);
    repeat (60) @(negedge clk);
    rd(ADDR_TIMER_ONE_LOW, r[7:0]);
    chk(r[7:0], v[7:0]);
    waitfor(1, 3200);
    chk(oo, 1'b1);
    waitfor(2, 1200);
    chk(zo, 1'b1);
    // high byte of timer zero must freeze once timer one's run bit drops
    ors = 1'b0;
    rd(ADDR_TIMER_ZERO_HIGH, v[7:0]);
    repeat (40) @(negedge clk);
    rd(ADDR_TIMER_ZERO_HIGH, r[7:0]);
    chk(r[7:0], v[7:0]);
    // split: both low bytes follow their own counter selects, timer one runs in mode 2
    zcs = 1'b1;
    ocs = 1'b1;
    om  = T1_MODE_RELOAD8;
    rd(ADDR_TIMER_ZERO_LOW, r[7:0]);
    rd(ADDR_TIMER_ONE_LOW, r[15:8]);
    repeat (3) begin
      pulse(PIN_T0);
      pulse(PIN_T1);
    end
    rd(ADDR_TIMER_ZERO_LOW, v[7:0]);
    rd(ADDR_TIMER_ONE_LOW, v[15:8]);
    chk(v[7:0], r[7:0] + 8'h03);
    chk(v[15:8], r[15:8] + 8'h03);
    end_sim();
  end
endmodule
